// file: src/fmsp_map.vh
// Function
// - One buffer address: reads give receive holding register, writes give transmit register.
// - Received bytes pass through a holding register, so shifting continues before reading.
// - Transmit-done (ctrl bit 1) and receive-done (ctrl bit 0) cleared only by software.
// - Four modes: synchronous 8-bit, async 8-bit timer, async 9-bit fixed, async 9-bit timer.
// - Mode 0 is master: data on receive pin, shift clock on transmit pin, half-duplex.
// - Mode 0 buffer write shifts eight bits LSB first; transmit-done at eighth bit end.
// - Mode 0 receive starts when enable set and receive-done clear; done one cycle later.
// - Mode 0 shift clock is system clock over twelve; receive pin open-drain.
// - Mode 1 frame is start, eight data LSB first, stop; stop goes to ninth field.
// - Async buffer write starts a frame; transmit-done set at the start of stop bit.
// - Mode 1 loads only if receive-done clear and, with multiprocessor on, stop is 1.
// - Timer 2 overflows, or timer 1 overflows (every second one without double-speed), clock a divide-by-16 stage giving the bit rate.
// - Timer 1 rate uses double-speed, timebase select and reload byte; double-speed resets 0.
// - Timer 2 as baud source blocks its interrupt, counts system_clock/2 or external pin.
// - Timer 2 rate is system_clock over 32 times (65536 minus 16-bit reload).
// - Mode 2 frame is start, eight data, transmit ninth bit from ctrl bit 3, stop.
// - Mode 2 ninth bit goes to receive ninth field; stop ignored; multiprocessor gates on it.
// - Mode 2 bit rate is system_clock over 64, or over 32 with double-speed.
// - Interrupt requested, when enabled, while transmit-done or receive-done is set.
// - Mode 3 frames like mode 2, baud from timer overflows like mode 1.
`ifndef FMSP_MAP_VH
`define FMSP_MAP_VH
// Register addresses
`define FMSP_ADDR_CTRL    4'h0
`define FMSP_ADDR_DATA    4'h1
`define FMSP_ADDR_POWER   4'h2
`define FMSP_ADDR_CLKCTL  4'h3
`define FMSP_ADDR_T1RLD   4'h4
`define FMSP_ADDR_T2RLDL  4'h5
`define FMSP_ADDR_T2RLDH  4'h6
`define FMSP_ADDR_T2CTL   4'h7
`define FMSP_ADDR_IEN     4'h8
// Control register fields, then power, clock control and timer 2 control bits
`define FMSP_CTL_RXDONE   0
`define FMSP_CTL_TXDONE   1
`define FMSP_CTL_RX9      2
`define FMSP_CTL_TX9      3
`define FMSP_CTL_RXEN     4
`define FMSP_CTL_MPEN     5
`define FMSP_CTL_MODE_LO  6
`define FMSP_CTL_MODE_HI  7
`define FMSP_PWR_DBL      7
`define FMSP_CLK_T1FAST   4
`define FMSP_T2_CNTSEL    1
`define FMSP_T2_TXSEL     4
`define FMSP_T2_RXSEL     5
// Reset values
`define FMSP_RST_BYTE     8'h00
`define FMSP_RST_WORD     16'h0000
// Timing counts in system clocks; oversampling counts in 16x ticks
`define FMSP_M0_DIV       4'hC
`define FMSP_M0_LAST      4'hB
`define FMSP_M0_RISE      4'h6
`define FMSP_T1_PRE_LAST  4'hB
`define FMSP_OVS_LAST     4'hF
`define FMSP_OVS_HALF     4'h7
`endif

// file: src/fmsp_baud_gen.v
`timescale 1ns/100ps
`include "fmsp_map.vh"
// Baud tick source: 16x ticks for receive and transmit
module fmsp_baud_gen (
  input  wire        clk_sys,     // System clock
  input  wire        reset_n,     // Async reset, active low
  input  wire [1:0]  mode,        // Port mode
  input  wire        doubleSpeed, // Double-speed bit
  input  wire        t1Fast,      // Timer 1 timebase select
  input  wire [7:0]  t1Reload,    // Timer 1 reload byte
  input  wire [15:0] t2Reload,    // Timer 2 reload pair
  input  wire        rxT2,        // Receive uses timer 2
  input  wire        txT2,        // Transmit uses timer 2
  input  wire        t2Counter,   // Timer 2 counts external pin
  input  wire        t2Ext,       // Synchronised external input
  output wire        rxTick16,    // Receive 16x tick
  output wire        txTick16     // Transmit 16x tick
);
  reg [3:0]  t1Pre;
  reg [7:0]  t1Cnt;
  reg        t1Half;
  reg        t2Pre;
  reg        t2ExtPrev;
  reg [15:0] t2Cnt;
  reg [1:0]  m2Cnt;
  wire t1Inc = t1Fast | (t1Pre == `FMSP_T1_PRE_LAST);
  wire t1Ovf = t1Inc & (t1Cnt == 8'hFF);
  wire t1Tick = t1Ovf & (doubleSpeed | t1Half);
  wire t2Run = rxT2 | txT2;
  wire t2Inc = t2Run & (t2Counter ? (t2Ext & ~t2ExtPrev) : t2Pre);
  wire t2Ovf = t2Inc & (t2Cnt == 16'hFFFF);
  wire m2Tick = (m2Cnt == (doubleSpeed ? 2'h1 : 2'h3));
  // Ticks are 16x bit rate; the bit engines divide by 16
  assign rxTick16 = (mode == 2'h2) ? m2Tick : (rxT2 ? t2Ovf : t1Tick);
  assign txTick16 = (mode == 2'h2) ? m2Tick : (txT2 ? t2Ovf : t1Tick);
  // Timer 1: 8-bit auto-reload; odd overflows dropped without double-speed
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      t1Pre  <= 4'h0;
      t1Cnt  <= 8'h00;
      t1Half <= 1'b0;
    end else begin
      t1Pre <= (t1Pre == `FMSP_T1_PRE_LAST) ? 4'h0 : t1Pre + 4'h1;
      if (t1Ovf) begin
        t1Cnt  <= t1Reload;
        t1Half <= ~t1Half;
      end else if (t1Inc) begin
        t1Cnt <= t1Cnt + 8'h01;
      end
    end
  end
  // Timer 2: 16-bit auto-reload, system_clock/2 or external rising edges
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      t2Pre     <= 1'b0;
      t2ExtPrev <= 1'b0;
      t2Cnt     <= 16'h0000;
      m2Cnt     <= 2'h0;
    end else begin
      t2Pre     <= ~t2Pre;
      t2ExtPrev <= t2Ext;
      if (t2Ovf) begin
        t2Cnt <= t2Reload;
      end else if (t2Inc) begin
        t2Cnt <= t2Cnt + 16'h0001;
      end else if (!t2Run) begin
        // Parked at reload: counter is not software visible, first period must be full
        t2Cnt <= t2Reload;
      end
      m2Cnt <= m2Tick ? 2'h0 : m2Cnt + 2'h1;
    end
  end
endmodule // fmsp_baud_gen

// file: src/fmsp_rx_async.v
`timescale 1ns/100ps
`include "fmsp_map.vh"
// Asynchronous frame receiver with 16x oversampling
module fmsp_rx_async (
  input  wire       clk_sys,    // System clock
  input  wire       reset_n,    // Async reset, active low
  input  wire       rxIn,       // Synchronised receive line
  input  wire       tick16,     // 16x bit tick
  input  wire       enable,     // Receive enabled in async mode
  input  wire       nineBits,   // Frame carries a ninth bit
  output reg        frameDone,  // One-cycle pulse after stop sample
  output reg  [7:0] frameData,  // Received data byte
  output reg        frameNinth, // Received ninth bit
  output reg        frameStop   // Received stop bit
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_BITS  = 2'h2;
  localparam ST_STOP  = 2'h3;
  reg [1:0] state;
  reg [3:0] ovs;
  reg [3:0] bitIdx;
  reg       rxPrev;
  wire [3:0] lastBit = nineBits ? 4'h8 : 4'h7;
  // Start on falling edge, verify at mid start bit, then sample centres
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state      <= ST_IDLE;
      ovs        <= 4'h0;
      bitIdx     <= 4'h0;
      rxPrev     <= 1'b1;
      frameDone  <= 1'b0;
      frameData  <= 8'h00;
      frameNinth <= 1'b0;
      frameStop  <= 1'b0;
    end else begin
      rxPrev    <= rxIn;
      frameDone <= 1'b0;
      case (state)
        ST_IDLE: begin
          ovs    <= 4'h0;
          bitIdx <= 4'h0;
          if (enable && rxPrev && !rxIn) begin
            state <= ST_START;
          end
        end
        ST_START: if (tick16) begin
          ovs <= ovs + 4'h1;
          if (ovs == `FMSP_OVS_HALF) begin
            ovs   <= 4'h0;
            state <= rxIn ? ST_IDLE : ST_BITS;
          end
        end
        ST_BITS: if (tick16) begin
          ovs <= ovs + 4'h1;
          if (ovs == `FMSP_OVS_LAST) begin
            if (bitIdx == 4'h8) begin
              frameNinth <= rxIn;
            end else begin
              frameData <= {rxIn, frameData[7:1]};
            end
            bitIdx <= bitIdx + 4'h1;
            if (bitIdx == lastBit) begin
              state <= ST_STOP;
            end
          end
        end
        ST_STOP: if (tick16) begin
          ovs <= ovs + 4'h1;
          if (ovs == `FMSP_OVS_LAST) begin
            frameStop <= rxIn;
            frameDone <= 1'b1;
            state     <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // fmsp_rx_async

// file: src/fmsp_serial_port.v
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "fmsp_map.vh"
// Four-mode serial port: register file, mode 0 shifter, async transmitter
module fmsp_serial_port (
  input  wire       clk_sys,       // System clock, 125 MHz
  input  wire       reset_n,       // Async reset, active low
  input  wire [3:0] regAddr,       // Register address
  input  wire [7:0] regWrData,     // Write data
  input  wire       regWr,         // Write strobe
  input  wire       regRd,         // Read strobe
  output reg  [7:0] regRdData,     // Read data, cycle after strobe
  input  wire       rxPin,         // Receive pin level
  output reg        rxPinOut,      // Receive pin drive value
  output reg        rxPinOeN,      // Receive pin enable, low drives
  output reg        txPin,         // Transmit pin / mode 0 clock
  input  wire       t2ExtPin,      // Timer 2 external input pin
  output reg        irq,           // Serial interrupt request
  output reg        t2IntBlock     // Timer 2 interrupt disabled
);
  // Mode 0 states
  localparam M0_IDLE = 2'h0;
  localparam M0_TX   = 2'h1;
  localparam M0_RX   = 2'h2;
  localparam M0_TAIL = 2'h3;

  // Software-visible registers
  reg [7:0]  serialCtl;
  reg [7:0]  rxBuf;
  reg [7:0]  txBuf;
  reg        doubleSpeed;
  reg        t1Fast;
  reg [7:0]  t1Reload;
  reg [15:0] t2Reload;
  reg        rxT2;
  reg        txT2;
  reg        t2Counter;
  reg        intEnable;

  // Pin synchronisers
  reg        rxMeta;
  reg        rxSync;
  reg        t2Meta;
  reg        t2Sync;

  // Mode 0 engine
  reg [1:0]  m0State;
  reg [3:0]  m0Phase;
  reg [2:0]  m0Bit;
  reg [7:0]  m0Shift;

  // Async transmitter
  reg        atBusy;
  reg [3:0]  atOvs;
  reg [3:0]  atIdx;
  reg [10:0] atShift;

  wire [1:0] mode = serialCtl[`FMSP_CTL_MODE_HI:`FMSP_CTL_MODE_LO];
  wire       isAsync = (mode != 2'h0);
  wire       nineBits = mode[1];
  wire       rxDone = serialCtl[`FMSP_CTL_RXDONE];
  wire       rxEn = serialCtl[`FMSP_CTL_RXEN];
  wire       mpEn = serialCtl[`FMSP_CTL_MPEN];

  wire       rxTick16;
  wire       txTick16;
  wire       frameDone;
  wire [7:0] frameData;
  wire       frameNinth;
  wire       frameStop;

  // Bus decode
  function isHit;
    input [3:0] a;
    input [3:0] target;
    begin
      isHit = (a == target);
    end
  endfunction

  wire wrCtl  = regWr & isHit(regAddr, `FMSP_ADDR_CTRL);
  wire wrData = regWr & isHit(regAddr, `FMSP_ADDR_DATA);

  // Baud timing from timers or fixed divider
  fmsp_baud_gen uBaud (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .mode        (mode),
    .doubleSpeed (doubleSpeed),
    .t1Fast      (t1Fast),
    .t1Reload    (t1Reload),
    .t2Reload    (t2Reload),
    .rxT2        (rxT2),
    .txT2        (txT2),
    .t2Counter   (t2Counter),
    .t2Ext       (t2Sync),
    .rxTick16    (rxTick16),
    .txTick16    (txTick16)
  );

  // Asynchronous receiver, shift register separate from holding buffer
  fmsp_rx_async uRx (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .rxIn       (rxSync),
    .tick16     (rxTick16),
    .enable     (rxEn & isAsync),
    .nineBits   (nineBits),
    .frameDone  (frameDone),
    .frameData  (frameData),
    .frameNinth (frameNinth),
    .frameStop  (frameStop)
  );

  // Two-flop synchronisers for pins from outside the clock domain
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      t2Meta <= 1'b0;
      t2Sync <= 1'b0;
    end else begin
      rxMeta <= rxPin;
      rxSync <= rxMeta;
      t2Meta <= t2ExtPin;
      t2Sync <= t2Meta;
    end
  end

  // Async receive acceptance: ninth bit or stop bit gates multiprocessor filter
  wire asyncGate = nineBits ? frameNinth : frameStop;
  wire asyncLoad = frameDone & isAsync & !rxDone & (!mpEn | asyncGate);

  // Mode 0 timing: low half then high half of a twelve-clock bit
  wire m0BitEnd = (m0Phase == `FMSP_M0_LAST);
  wire m0Rise = (m0Phase == `FMSP_M0_RISE);
  wire m0TxDone = (m0State == M0_TX) & m0BitEnd & (m0Bit == 3'h7);
  wire m0RxLoad = (m0State == M0_TAIL);

  // Async transmit: done flag at entry of stop bit
  wire [3:0] atLast = nineBits ? 4'hA : 4'h9;
  wire atBitEnd = atBusy & txTick16 & (atOvs == `FMSP_OVS_LAST);
  wire atTxDone = atBitEnd & ((atIdx + 4'h1) == atLast);

  wire setTxDone = m0TxDone | atTxDone;
  wire setRxDone = m0RxLoad | asyncLoad;

  // Control register; hardware set wins over a software clear
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serialCtl <= `FMSP_RST_BYTE;
    end else begin
      if (wrCtl) begin
        serialCtl <= regWrData;
      end
      if (asyncLoad) begin
        serialCtl[`FMSP_CTL_RX9] <= asyncGate;
      end
      if (setTxDone) begin
        serialCtl[`FMSP_CTL_TXDONE] <= 1'b1;
      end
      if (setRxDone) begin
        serialCtl[`FMSP_CTL_RXDONE] <= 1'b1;
      end
    end
  end

  // Holding register: only loaded when a frame is accepted
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxBuf <= `FMSP_RST_BYTE;
    end else if (asyncLoad) begin
      rxBuf <= frameData;
    end else if (m0RxLoad) begin
      rxBuf <= m0Shift;
    end
  end

  // Remaining configuration registers
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txBuf       <= `FMSP_RST_BYTE;
      doubleSpeed <= 1'b0;
      t1Fast      <= 1'b0;
      t1Reload    <= `FMSP_RST_BYTE;
      t2Reload    <= `FMSP_RST_WORD;
      rxT2        <= 1'b0;
      txT2        <= 1'b0;
      t2Counter   <= 1'b0;
      intEnable   <= 1'b0;
    end else if (regWr) begin
      case (regAddr)
        `FMSP_ADDR_DATA:   txBuf <= regWrData;
        `FMSP_ADDR_POWER:  doubleSpeed <= regWrData[`FMSP_PWR_DBL];
        `FMSP_ADDR_CLKCTL: t1Fast <= regWrData[`FMSP_CLK_T1FAST];
        `FMSP_ADDR_T1RLD:  t1Reload <= regWrData;
        `FMSP_ADDR_T2RLDL: t2Reload[7:0] <= regWrData;
        `FMSP_ADDR_T2RLDH: t2Reload[15:8] <= regWrData;
        `FMSP_ADDR_T2CTL: begin
          rxT2      <= regWrData[`FMSP_T2_RXSEL];
          txT2      <= regWrData[`FMSP_T2_TXSEL];
          t2Counter <= regWrData[`FMSP_T2_CNTSEL];
        end
        `FMSP_ADDR_IEN:    intEnable <= regWrData[0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= `FMSP_RST_BYTE;
    end else if (regRd) begin
      case (regAddr)
        `FMSP_ADDR_CTRL:   regRdData <= serialCtl;
        `FMSP_ADDR_DATA:   regRdData <= rxBuf;
        `FMSP_ADDR_POWER:  regRdData <= {doubleSpeed, 7'h00};
        `FMSP_ADDR_CLKCTL: regRdData <= {3'h0, t1Fast, 4'h0};
        `FMSP_ADDR_T1RLD:  regRdData <= t1Reload;
        `FMSP_ADDR_T2RLDL: regRdData <= t2Reload[7:0];
        `FMSP_ADDR_T2RLDH: regRdData <= t2Reload[15:8];
        `FMSP_ADDR_T2CTL:  regRdData <= {2'h0, rxT2, txT2, 2'h0, t2Counter, 1'b0};
        `FMSP_ADDR_IEN:    regRdData <= {7'h00, intEnable};
        default:           regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // Mode 0 half-duplex master; transmit has priority over a pending receive
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      m0State <= M0_IDLE;
      m0Phase <= 4'h0;
      m0Bit   <= 3'h0;
      m0Shift <= 8'h00;
    end else begin
      case (m0State)
        M0_IDLE: begin
          m0Phase <= 4'h0;
          m0Bit   <= 3'h0;
          if (!isAsync && wrData) begin
            m0Shift <= regWrData;
            m0State <= M0_TX;
          end else if (!isAsync && rxEn && !rxDone) begin
            m0State <= M0_RX;
          end
        end
        M0_TX: begin
          m0Phase <= m0BitEnd ? 4'h0 : m0Phase + 4'h1;
          if (m0BitEnd) begin
            m0Shift <= {1'b1, m0Shift[7:1]};
            m0Bit   <= m0Bit + 3'h1;
            if (m0Bit == 3'h7) begin
              m0State <= M0_IDLE;
            end
          end
        end
        M0_RX: begin
          m0Phase <= m0BitEnd ? 4'h0 : m0Phase + 4'h1;
          if (m0Rise) begin
            m0Shift <= {rxSync, m0Shift[7:1]};
          end
          if (m0BitEnd) begin
            m0Bit <= m0Bit + 3'h1;
            if (m0Bit == 3'h7) begin
              m0State <= M0_TAIL;
            end
          end
        end
        M0_TAIL: m0State <= M0_IDLE;
        default: m0State <= M0_IDLE;
      endcase
      // A switch to an async mode abandons any shift in flight
      if (isAsync) begin
        m0State <= M0_IDLE;
      end
    end
  end

  // Async transmitter: start, data LSB first, optional ninth bit, stop
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      atBusy  <= 1'b0;
      atOvs   <= 4'h0;
      atIdx   <= 4'h0;
      atShift <= 11'h7FF;
    end else if (!atBusy) begin
      atOvs <= 4'h0;
      atIdx <= 4'h0;
      if (isAsync && wrData) begin
        atBusy <= 1'b1;
        // Mode 1 puts the stop level where the ninth bit would sit
        atShift <= {1'b1, (nineBits ? serialCtl[`FMSP_CTL_TX9] : 1'b1), regWrData, 1'b0};
      end
    end else if (txTick16) begin
      atOvs <= atOvs + 4'h1;
      if (atBitEnd) begin
        atShift <= {1'b1, atShift[10:1]};
        atIdx   <= atIdx + 4'h1;
        // At or past last: a mode change mid-frame must not wrap the index
        if (atIdx >= atLast) begin
          atBusy <= 1'b0;
        end
      end
    end
  end

  // Pin outputs, all registered
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txPin    <= 1'b1;
      rxPinOut <= 1'b0;
      rxPinOeN <= 1'b1;
    end else if (!isAsync) begin
      // Shift clock low for the first half of each bit
      txPin    <= (m0State == M0_TX || m0State == M0_RX) ? (m0Phase >= `FMSP_M0_RISE) : 1'b1;
      rxPinOut <= 1'b0;
      // Open-drain: pull low for a zero, release otherwise
      rxPinOeN <= !((m0State == M0_TX) && !m0Shift[0]);
    end else begin
      txPin    <= atBusy ? atShift[0] : 1'b1;
      rxPinOut <= 1'b0;
      rxPinOeN <= 1'b1;
    end
  end

  // Interrupt level and timer 2 interrupt block
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq        <= 1'b0;
      t2IntBlock <= 1'b0;
    end else begin
      irq        <= intEnable & (serialCtl[`FMSP_CTL_TXDONE] | rxDone);
      t2IntBlock <= rxT2 | txT2;
    end
  end
endmodule // fmsp_serial_port

// file: test/fmsp_serial_port_sva.sv
`timescale 1ns/100ps
// Port-level timing checks for the serial port
module fmsp_port_chk (
  input wire       clk_sys,   // System clock
  input wire       reset_n,   // Async reset, active low
  input wire [3:0] regAddr,   // Register address
  input wire [7:0] regWrData, // Write data
  input wire       regWr,     // Write strobe
  input wire       regRd,     // Read strobe
  input wire [7:0] regRdData, // Read data
  input wire       rxPinOut,  // Receive pin drive value
  input wire       rxPinOeN,  // Receive pin enable
  input wire       txPin,     // Transmit pin / shift clock
  input wire       irq,       // Interrupt request
  input wire       t2IntBlock // Timer 2 interrupt block
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Control write followed at once by a control read
  sequence ctlWrRd;
    regWr && regAddr == 4'h0 ##1 regRd && regAddr == 4'h0;
  endsequence
  chk_reset_idle: assert property ($rose(reset_n) |-> txPin && rxPinOeN && !irq)
    else $error("outputs not idle after reset");
  chk_read_quiet: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside read slot");
  chk_unmapped_zero: assert property (regRd && regAddr > 4'h8 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_ctl_back: assert property (ctlWrRd |=> (regRdData >> 3) == ($past(regWrData, 2) >> 3))
    else $error("control readback wrong");
  chk_drive_low: assert property (rxPinOut == 1'b0)
    else $error("receive pin driven high");
  chk_clk_low: assert property ($fell(txPin) |=> !txPin [*5])
    else $error("transmit low phase too short");
  chk_clk_high: assert property ($rose(txPin) |=> txPin [*5])
    else $error("transmit high phase too short");
  chk_bit_hold: assert property ($fell(rxPinOeN) |=> !rxPinOeN [*8])
    else $error("shift data not held");
  chk_t2_release: assert property (regWr && regAddr == 4'h7 && regWrData[5:4] == 2'b00
    |-> ##[1:3] !t2IntBlock)
    else $error("timer 2 block stuck");
  chk_irq_mask: assert property (regWr && regAddr == 4'h8 && !regWrData[0] |-> ##[1:3] !irq)
    else $error("masked interrupt still raised");
endmodule // fmsp_port_chk

bind fmsp_serial_port fmsp_port_chk chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxPinOut(rxPinOut),
  .rxPinOeN(rxPinOeN), .txPin(txPin), .irq(irq), .t2IntBlock(t2IntBlock));

// file: test/fmsp_remote_dev.sv
`timescale 1ns/100ps
// Remote serial device on the far side of the pins
module fmsp_remote_dev (
  input  wire clk_sys,  // System clock
  input  wire txLine,   // Port transmit pin / shift clock
  input  wire dataLine, // Resolved receive wire
  output reg  drive     // Our level on the wire, 1 releases to pull-up
);
  integer i;
  integer n;
  integer lost;
  initial begin
    drive = 1'b1;
    lost = 0;
  end
  // Bounded wait; sampled mid-cycle so port updates have settled
  task waitTx(input lvl);
    n = 0;
    while (txLine !== lvl && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 5000) lost++;
  endtask
  // Async frame, LSB first, stop bit last, then release
  task sendAsync(input [10:0] bits, input integer nb, input integer bc);
    @(posedge clk_sys);
    for (i = 0; i < nb; i++) begin
      drive <= bits[i];
      repeat (bc) @(posedge clk_sys);
    end
    drive <= 1'b1;
  endtask
  // Sample an async frame at bit centres
  task capAsync(input integer nb, input integer bc, output [10:0] bits);
    bits = 11'h000;
    waitTx(1'b0);
    repeat (bc / 2) @(negedge clk_sys);
    bits[0] = txLine;
    for (i = 1; i < nb; i++) begin
      repeat (bc) @(negedge clk_sys);
      bits[i] = txLine;
    end
  endtask
  // Shift slave: new bit once the port has sampled on the rising shift clock
  task sendSync(input [7:0] b);
    @(posedge clk_sys);
    drive <= b[0];
    for (i = 0; i < 8; i++) begin
      waitTx(1'b0);
      waitTx(1'b1);
      @(posedge clk_sys);
      drive <= (i < 7) ? b[i + 1] : 1'b1;
    end
  endtask
  // Shift slave: take data on each rising shift clock
  task capSync(output [7:0] b);
    for (i = 0; i < 8; i++) begin
      waitTx(1'b0);
      waitTx(1'b1);
      b[i] = dataLine;
    end
  endtask
endmodule // fmsp_remote_dev

// file: test/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        clk_sys;
  logic        reset_n;
  logic [3:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regRdData;
  logic        rxPinOut;
  logic        rxPinOeN;
  logic        txPin;
  logic        irq;
  logic        t2IntBlock;
  logic        remoteDrive;
  logic [7:0]  rdv;
  logic [10:0] fr;
  integer      fails = 0;
  integer      checks = 0;
  logic [1:0]  extDiv = 2'h0;
  // Open-drain wire: port pulls low, remote releases to the pull-up
  wire rxWire = (!rxPinOeN && !rxPinOut) ? 1'b0 : remoteDrive;
  fmsp_serial_port dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxPin(rxWire),
    .rxPinOut(rxPinOut), .rxPinOeN(rxPinOeN), .txPin(txPin), .t2ExtPin(extDiv[1]),
    .irq(irq), .t2IntBlock(t2IntBlock));
  fmsp_remote_dev remote_u (.clk_sys(clk_sys), .txLine(txPin), .dataLine(rxWire), .drive(remoteDrive));
  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Slow external count for timer 2, one rising edge every four clocks
  always @(posedge clk_sys) extDiv <= extDiv + 2'h1;
  task check(input [15:0] seen, input [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Any lost handshake on the line ends the run
  task alive;
    check(remote_u.lost[15:0], 16'h0000);
    if (remote_u.lost != 0) final_report;
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task rd(input [3:0] a);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 rdv = regRdData;
  endtask
  // Reset values, unmapped read, back-to-back control readback
  task scnReset;
    rd(4'h0);
    check(rdv, 8'h00);
    rd(4'h2);
    check(rdv, 8'h00);
    rd(4'h9);
    check(rdv, 8'h00);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= 4'h0;
    regWrData <= 8'h48;
    @(posedge clk_sys);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 check(regRdData >> 3, 8'h09);
  endtask
  // Mode 2 send: ninth bit, done at stop start, interrupt and clear
  task scnMode2Tx;
    wr(4'h0, 8'h88);
    wr(4'h1, 8'hA5);
    remote_u.capAsync(10, 64, fr);
    alive;
    check(fr[9:0], 10'h34A);
    rd(4'h0);
    check(rdv[1], 1'b0);
    repeat (40) @(posedge clk_sys);
    rd(4'h0);
    check(rdv[1], 1'b1);
    check(txPin, 1'b1);
    wr(4'h8, 8'h01);
    repeat (3) @(posedge clk_sys);
    check(irq, 1'b1);
    rd(4'h0);
    check(rdv[1], 1'b1);
    wr(4'h0, 8'h88);
    repeat (3) @(posedge clk_sys);
    check(irq, 1'b0);
  endtask
  // Mode 2 receive at double speed with multiprocessor gate
  task scnMode2Rx;
    wr(4'h2, 8'h80);
    wr(4'h0, 8'hB0);
    remote_u.sendAsync({1'b1, 1'b0, 8'h3C, 1'b0}, 11, 32);
    rd(4'h0);
    check(rdv[0], 1'b0);
    remote_u.sendAsync({1'b1, 1'b1, 8'h5A, 1'b0}, 11, 32);
    rd(4'h0);
    check(rdv[2:0], 3'b101);
    remote_u.sendAsync({1'b1, 1'b1, 8'h11, 1'b0}, 11, 32);
    rd(4'h1);
    check(rdv, 8'h5A);
  endtask
  // Mode 1 on timer 1, both directions
  task scnMode1;
    wr(4'h3, 8'h10);
    wr(4'h4, 8'hFE);
    // Let timer 1 pass one overflow so the new reload governs every tick
    repeat (260) @(posedge clk_sys);
    wr(4'h0, 8'h70);
    wr(4'h1, 8'h96);
    remote_u.capAsync(10, 32, fr);
    alive;
    check(fr[9:0], {1'b1, 8'h96, 1'b0});
    remote_u.sendAsync({2'b01, 8'hC3, 1'b0}, 10, 32);
    rd(4'h0);
    check(rdv[2:0], 3'b111);
    rd(4'h1);
    check(rdv, 8'hC3);
  endtask
  // Mode 3 on timer 2
  task scnMode3;
    wr(4'h5, 8'hFE);
    wr(4'h6, 8'hFF);
    wr(4'h7, 8'h30);
    wr(4'h0, 8'hD0);
    check(t2IntBlock, 1'b1);
    wr(4'h1, 8'h3C);
    remote_u.capAsync(11, 64, fr);
    alive;
    check(fr, 11'h478);
    remote_u.sendAsync({2'b11, 8'h69, 1'b0}, 11, 64);
    rd(4'h1);
    check(rdv, 8'h69);
    // Timer 2 counting the external pin: four clocks per count
    wr(4'h7, 8'h12);
    wr(4'h1, 8'h5B);
    remote_u.capAsync(11, 128, fr);
    alive;
    check(fr, {2'b10, 8'h5B, 1'b0});
    wr(4'h7, 8'h00);
  endtask
  // Mode 0 shift out, then shift in
  task scnMode0;
    wr(4'h0, 8'h00);
    wr(4'h1, 8'hB4);
    remote_u.capSync(rdv);
    alive;
    check(rdv, 8'hB4);
    repeat (8) @(posedge clk_sys);
    rd(4'h0);
    check(rdv[1], 1'b1);
    wr(4'h0, 8'h10);
    remote_u.sendSync(8'h6D);
    alive;
    repeat (4) @(posedge clk_sys);
    rd(4'h0);
    check(rdv[0], 1'b1);
    rd(4'h1);
    check(rdv, 8'h6D);
    wr(4'h8, 8'h00);
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    scnReset;
    scnMode2Tx;
    scnMode2Rx;
    scnMode1;
    scnMode3;
    scnMode0;
    final_report;
  end
endmodule // testbench
